// ==== rtl/stht_pkg.sv ====
// Constants for the target handshake timing block
package stht_pkg;
  // Register offsets are printed as indices 13 and 23; byte address is x4
  localparam int unsigned PERIOD_IDX   = 13;
  localparam int unsigned SETUP_IDX    = 23;
  localparam int unsigned CTRL_IDX     = 24;
  localparam int unsigned STAT_IDX     = 25;
  localparam int unsigned TXDATA_IDX   = 26;
  localparam int unsigned RXDATA_IDX   = 27;
  localparam logic [11:0] PERIOD_ADDR  = 12'(PERIOD_IDX * 4);
  localparam logic [11:0] SETUP_ADDR   = 12'(SETUP_IDX * 4);
  localparam logic [11:0] CTRL_ADDR    = 12'(CTRL_IDX * 4);
  localparam logic [11:0] STAT_ADDR    = 12'(STAT_IDX * 4);
  localparam logic [11:0] TXDATA_ADDR  = 12'(TXDATA_IDX * 4);
  localparam logic [11:0] RXDATA_ADDR  = 12'(RXDATA_IDX * 4);
  localparam logic [7:0]  PERIOD_RST   = 8'h00;
  localparam logic [7:0]  SETUP_RST    = 8'h00;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  // Control bits
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_SYNC_BIT = 1;
  localparam int unsigned CTRL_OUT_BIT  = 2;
  // Timing, FIFO depth and data width
  localparam int unsigned CLK_PS       = 5000;
  localparam int unsigned HOLD_CLKS    = 2;
  localparam int unsigned INHIBIT_CODE = 1;
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam int unsigned DATA_W       = 8;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_ASRT  = 3'b011,
    ST_NEG   = 3'b010,
    ST_HOLD  = 3'b110
  } stht_state_t;
endpackage : stht_pkg

// ==== rtl/stht_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module stht_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  always_ff @(posedge hclk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule : stht_fifo

// ==== rtl/stht_target.sv ====
// Target-side REQ/ACK handshake timer with AHB-Lite registers
`timescale 1ns/1ps
// Functional notes
// RQ1: Period code 0 gives 16/16, code 1 inhibited, else ceil and floor halves.
// RQ2: Sync REQ held asserted A cycles and negated N cycles.
// RQ3: Sync output data valid N cycles before REQ, held A cycles after.
// RQ4: Setup code gives its value in cycles, code 0 gives 16.
// RQ5: Async output data placed S cycles before REQ; setup at index 23.
// RQ6: Async output data held two clocks after ACK asserts.
// RQ7: REQ negates after ACK asserts; next REQ after ACK negates.
// RQ8: Async input ACK-to-next-REQ at most three clocks plus 40 ns.
// RQ9: Input suspends REQ while the FIFO is full.
// RQ10: Output withholds REQ while the FIFO is empty.
// RQ11: Initiator holds ACK asserted and negated at least 20 ns.
// RQ12: Counters reload at REQ edges; settings latch at transfer start.
module stht_target
  import stht_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ack_in,
  input  wire logic [7:0]  data_in,
  output logic             req_out,
  output logic [7:0]       data_out,
  output logic             data_oe
);
  // A = ceil(v/2), N = floor(v/2), 0 -> 16/16
  function automatic logic [4:0] asrt_cnt(input logic [4:0] v);
    asrt_cnt = (v == 5'h00) ? 5'h10 : 5'((6'(v) + 6'h01) >> 1); // RQ1
  endfunction : asrt_cnt
  function automatic logic [4:0] neg_cnt(input logic [4:0] v);
    neg_cnt = (v == 5'h00) ? 5'h10 : 5'(v >> 1); // RQ1
  endfunction : neg_cnt

  logic [7:0]  period_q;
  logic [7:0]  setup_q;
  logic [7:0]  ctrl_q;
  logic        dph_q;
  logic        dwr_q;
  logic [11:0] daddr_q;
  logic [31:0] hrdata_q;
  logic [1:0]  ack_s_q;
  logic        ack_q;
  logic [7:0]  din_s1_q;
  logic [7:0]  din_q;
  logic        req_q;
  logic [7:0]  dout_q;
  logic        oe_q;
  logic [4:0]  cnt_q;
  logic [4:0]  a_q;
  logic [4:0]  n_q;
  logic        sync_q;
  logic        outd_q;
  stht_state_t st_q;

  // Pins pass two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_s_q  <= 2'b00;
      ack_q    <= 1'b0;
      din_s1_q <= 8'h00;
      din_q    <= 8'h00;
    end else begin
      ack_s_q  <= {ack_s_q[0], ack_in};
      ack_q    <= ack_s_q[1];
      din_s1_q <= data_in;
      din_q    <= din_s1_q;
    end
  end
  wire ack_a = ack_s_q[1];
  wire ack_rise = ack_a && !ack_q;

  // Bus slave; zero wait states
  wire        addr_ok = hsel && hready && htrans[1];
  wire        wr_en   = dph_q && dwr_q;
  wire        rd_ph   = addr_ok && !hwrite;
  wire        rd_pop  = rd_ph && (haddr == RXDATA_ADDR);
  wire        wr_push = wr_en && (daddr_q == TXDATA_ADDR);
  logic [7:0] tx_d, rx_d;
  logic       tx_v, tx_pop;
  logic       rx_v, rx_rdy, rx_push;

  stht_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx (
    .hclk(hclk), .hresetn(hresetn),
    .in_data(hwdata[7:0]), .in_valid(wr_push), .in_ready(),
    .out_data(tx_d), .out_valid(tx_v), .out_ready(tx_pop)
  );
  stht_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx (
    .hclk(hclk), .hresetn(hresetn),
    .in_data(din_q), .in_valid(rx_push), .in_ready(rx_rdy),
    .out_data(rx_d), .out_valid(rx_v), .out_ready(rd_pop)
  );
  wire [31:0] rd_mux =
    (haddr == PERIOD_ADDR) ? {24'h000000, 3'h0, period_q[4:0]} :
    (haddr == SETUP_ADDR)  ? {24'h000000, 4'h0, setup_q[3:0]} :
    (haddr == CTRL_ADDR)   ? {24'h000000, ctrl_q} :
    (haddr == STAT_ADDR)   ? {24'h000000, 1'b0, st_q, rx_v, !rx_rdy,
                              tx_v, req_q} :
    (haddr == RXDATA_ADDR) ? {24'h000000, rx_d} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q    <= 1'b0;
      dwr_q    <= 1'b0;
      daddr_q  <= 12'h000;
      hrdata_q <= 32'h00000000;
    end else begin
      dph_q   <= addr_ok;
      dwr_q   <= hwrite;
      daddr_q <= haddr;
      if (rd_ph) hrdata_q <= rd_mux;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_q <= PERIOD_RST;
      setup_q  <= SETUP_RST;
      ctrl_q   <= CTRL_RST;
    end else if (wr_en) begin
      if (daddr_q == PERIOD_ADDR) period_q <= {3'h0, hwdata[4:0]};
      if (daddr_q == SETUP_ADDR)  setup_q  <= {4'h0, hwdata[3:0]};
      if (daddr_q == CTRL_ADDR)   ctrl_q   <= hwdata[7:0];
    end
  end
  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Handshake engine
  wire [4:0] s_cnt   = (setup_q[3:0] == 4'h0) ? 5'h10
                                              : {1'b0, setup_q[3:0]}; // RQ4
  wire       inhibit = period_q[4:0] == 5'(INHIBIT_CODE); // RQ1
  wire       en      = ctrl_q[CTRL_EN_BIT] &&
                       !(ctrl_q[CTRL_SYNC_BIT] && inhibit);
  // Start needs data to send, or room to receive
  wire       can_go  = ctrl_q[CTRL_OUT_BIT] ? tx_v : rx_rdy; // RQ9 RQ10
  wire       last1   = cnt_q <= 5'h01;
  // Pop only when the start really happens, else a byte is lost
  wire       idle_go   = en && can_go && !ack_a;
  wire       sync_next = (st_q == ST_ASRT) && sync_q && last1 && outd_q &&
                         tx_v;
  assign tx_pop  = ((st_q == ST_IDLE) && idle_go && ctrl_q[CTRL_OUT_BIT]) ||
                   sync_next; // RQ10
  assign rx_push = !outd_q && req_q &&
                   (sync_q ? (st_q == ST_ASRT && last1) : ack_rise);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 5'h00;
      a_q    <= 5'h01;
      n_q    <= 5'h01;
      sync_q <= 1'b0;
      outd_q <= 1'b0;
      req_q  <= 1'b0;
      dout_q <= 8'h00;
      oe_q   <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (idle_go) begin
            // Settings latch here only
            sync_q <= ctrl_q[CTRL_SYNC_BIT]; // RQ12
            outd_q <= ctrl_q[CTRL_OUT_BIT];
            a_q    <= asrt_cnt(period_q[4:0]); // RQ1
            n_q    <= neg_cnt(period_q[4:0]);
            if (ctrl_q[CTRL_OUT_BIT]) begin
              dout_q <= tx_d;
              oe_q   <= 1'b1;
              cnt_q  <= ctrl_q[CTRL_SYNC_BIT] ? neg_cnt(period_q[4:0])
                                              : s_cnt; // RQ3 RQ5
              st_q   <= ST_SETUP;
            end else begin
              req_q  <= 1'b1;
              cnt_q  <= asrt_cnt(period_q[4:0]); // RQ12
              st_q   <= ST_ASRT;
            end
          end
        end
        ST_SETUP: begin
          if (last1) begin
            req_q <= 1'b1; // RQ3 RQ5
            cnt_q <= a_q; // RQ12
            st_q  <= ST_ASRT;
          end else cnt_q <= cnt_q - 5'h01;
        end
        ST_ASRT: begin
          if (sync_q ? last1 : ack_a) begin
            req_q <= 1'b0; // RQ2 RQ7
            cnt_q <= sync_q ? n_q : 5'(HOLD_CLKS); // RQ12 RQ6
            if (sync_next) begin
              // Negation doubles as setup of the next byte
              dout_q <= tx_d; // RQ2 RQ3
              st_q   <= ST_SETUP;
            end else st_q <= sync_q ? ST_NEG : ST_HOLD;
          end else if (sync_q) cnt_q <= cnt_q - 5'h01;
        end
        ST_HOLD: begin
          // Data kept two clocks past ACK, and ACK must fall first
          if (cnt_q > 5'h00) cnt_q <= cnt_q - 5'h01; // RQ6
          else if (!ack_a) begin
            oe_q <= 1'b0; // RQ7 RQ8
            st_q <= ST_IDLE;
          end
        end
        ST_NEG: begin
          // Input streams on; output ends here when the FIFO ran dry
          if (last1 && !outd_q && en && rx_rdy) begin
            req_q <= 1'b1; // RQ2 RQ9
            cnt_q <= a_q; // RQ12
            st_q  <= ST_ASRT;
          end else if (last1) begin
            oe_q <= 1'b0; // RQ2 RQ3
            st_q <= ST_IDLE;
          end else cnt_q <= cnt_q - 5'h01;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign req_out  = req_q;
  assign data_out = dout_q;
  assign data_oe  = oe_q;

  a_async_neg: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    (st_q == ST_ASRT && !sync_q && ack_a) |=> !req_q)
    else $error("REQ not negated after ACK");
  a_sync_asrt: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
    $rose(req_q) && sync_q |-> req_q [*2] or (a_q == 5'h01))
    else $error("sync REQ assertion too short");
  a_full_stall: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
    (st_q == ST_IDLE && !ctrl_q[CTRL_OUT_BIT] && !rx_rdy) |=> !req_q)
    else $error("REQ raised with FIFO full");
  a_empty_stall: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    (st_q == ST_IDLE && ctrl_q[CTRL_OUT_BIT] && !tx_v) |=> !oe_q)
    else $error("output started with FIFO empty");
  a_out_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
    (outd_q && !sync_q && $fell(req_q)) |-> oe_q [*3])
    else $error("async data dropped early");
  a_setup_req: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    ($rose(req_q) && outd_q) |-> $past(oe_q))
    else $error("REQ before data setup");
  a_inhibit: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    (st_q == ST_IDLE && ctrl_q[CTRL_SYNC_BIT] && inhibit) |=> st_q == ST_IDLE)
    else $error("inhibited period started");
  a_async_next: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    (st_q == ST_HOLD && cnt_q == 5'h00 && !ack_a) |=> st_q == ST_IDLE)
    else $error("next transfer delayed");
  c_async_out: cover property (@(posedge hclk) outd_q && !sync_q && $fell(req_q));
  c_sync_in: cover property (@(posedge hclk) !outd_q && sync_q && rx_push);
  c_full: cover property (@(posedge hclk) !rx_rdy);
endmodule : stht_target

// ==== verification/stht_initiator.sv ====
// Initiator model facing the target handshake
`timescale 1ns/1ps
module stht_initiator (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       req_out,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_out,
  input  wire logic       slow,
  output logic            ack_in,
  output logic [7:0]      data_in,
  output logic [7:0]      got
);
  logic [7:0] nxt_q;
  int         cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_in  <= 1'b0;
      data_in <= 8'hA5;
      got     <= 8'h00;
      nxt_q   <= 8'h5A;
      cnt_q   <= 0;
    end else if (ack_in !== req_out) begin
      // Five cycles at least, above the 20 ns minimum
      cnt_q <= cnt_q + 1;
      if (!ack_in && !data_oe) data_in <= nxt_q;
      if (cnt_q >= (slow ? 9 : 4)) begin
        ack_in <= req_out;
        cnt_q  <= 0;
        if (req_out) got <= data_out;
        if (!req_out && !data_oe) nxt_q <= nxt_q + 8'h01;
      end
    end else if (!ack_in) begin
      // Released bus, alternating the last byte with its inverse each clock
      data_in <= ~data_in;
    end
  end
endmodule : stht_initiator

// ==== verification/tb.sv ====
// Self-checking bench for the target handshake timer
`timescale 1ns/1ps
module tb;
  import stht_pkg::*;
  localparam int LIM = 400;
  logic        hclk, hresetn, hsel, hwrite, ack_in, slow, hreadyout, hresp;
  logic        req_out, data_oe;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, r32;
  logic [7:0]  data_in, data_out, got, b, v;
  logic [31:0] seed = 32'hE1DD5B1F;
  int          n_errors = 0, total_checks = 0, i, k, t;
  stht_target dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ack_in(ack_in),
    .data_in(data_in), .req_out(req_out), .data_out(data_out),
    .data_oe(data_oe));
  stht_initiator ini (.hclk(hclk), .hresetn(hresetn), .req_out(req_out),
    .data_oe(data_oe), .data_out(data_out), .slow(slow), .ack_in(ack_in),
    .data_in(data_in), .got(got));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int a_of(int c);
    return c == 0 ? 16 : (c + 1) / 2;
  endfunction : a_of
  function automatic int n_of(int c);
    return c == 0 ? 16 : c / 2;
  endfunction : n_of
  function automatic int s_of(int c);
    return c == 0 ? 16 : c;
  endfunction : s_of
  function automatic logic sig(int w);
    return w == 0 ? req_out : (w == 1 ? data_oe : ack_in);
  endfunction : sig
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_cnt(input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h..%0h", $time, g, lo, hi);
    end
  endtask : chk_cnt
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < LIM);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < LIM);
    r = hrdata;
    if (n >= LIM) chk_cnt(n, 0, LIM - 1);
  endtask : ahb
  task automatic wait_on(input int w, input logic lvl, output int n);
    n = 0;
    while (sig(w) !== lvl && n < LIM) begin @(posedge hclk); n++; end
    if (n >= LIM) chk_cnt(n, 0, LIM - 1);
  endtask : wait_on
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    complete_run();
  end
  initial begin
    {hresetn, hsel, hwrite, slow, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1, 12'hF00, 32'hFFFFFFFF, rd);
    chk_val(32'({hreadyout, hresp}), 32'h00000002);
    ahb(0, PERIOD_ADDR, 0, rd); chk_val(rd, 32'(PERIOD_RST));
    ahb(0, SETUP_ADDR, 0, rd); chk_val(rd, 32'(SETUP_RST));
    ahb(0, 12'hF00, 0, rd); chk_val(rd, 32'h0);
    $display("test reset done");
    r32 = xs();
    slow <= r32[0];
    ahb(1, CTRL_ADDR, 32'h1, rd);
    k = 0;
    do begin ahb(0, STAT_ADDR, 0, rd); k++; end while (rd[2] !== 1'b1 && k < LIM);
    for (i = 0; i < 40; i++) begin @(posedge hclk); chk_val(32'(req_out), 0); end
    ahb(1, CTRL_ADDR, 32'h0, rd);
    for (i = 0; i < 32; i++) begin ahb(0, RXDATA_ADDR, 0, rd); chk_val(rd, 32'(8'h5A + 8'(i))); end
    ahb(0, STAT_ADDR, 0, rd); chk_val(32'(rd[3]), 0);
    $display("test async input done");
    for (k = 0; k < 4; k++) begin
      r32 = xs();
      b = r32[15:8];
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : (k == 2) ? 8'h0F : 8'(r32[3:0]);
      slow <= r32[16];
      ahb(1, SETUP_ADDR, 32'(v), rd);
      ahb(1, TXDATA_ADDR, 32'(b), rd);
      ahb(1, CTRL_ADDR, 32'h5, rd);
      wait_on(1, 1'b1, t);
      wait_on(0, 1'b1, t); chk_cnt(t, s_of(v), s_of(v) + 1);
      wait_on(2, 1'b1, t);
      repeat (2) begin @(posedge hclk); chk_val(32'(data_oe), 1); end
      wait_on(0, 1'b0, t); chk_cnt(t, 0, 9);
      chk_val(32'(got), 32'(b));
      wait_on(1, 1'b0, t);
      for (i = 0; i < 20; i++) begin @(posedge hclk); chk_val(32'(req_out), 0); end
      ahb(1, CTRL_ADDR, 32'h0, rd);
    end
    $display("test async output done");
    for (k = 0; k < 4; k++) begin
      r32 = xs();
      b = r32[15:8];
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h02 : (k == 2) ? 8'h1F : 8'(2 + r32[23:16] % 30);
      ahb(1, PERIOD_ADDR, 32'(v), rd);
      ahb(0, PERIOD_ADDR, 0, rd); chk_val(rd, 32'(v));
      ahb(1, TXDATA_ADDR, 32'(b), rd);
      ahb(1, TXDATA_ADDR, 32'(b + 8'h01), rd);
      ahb(1, CTRL_ADDR, 32'h7, rd);
      wait_on(0, 1'b1, t); chk_val(32'(data_out), 32'(b));
      wait_on(0, 1'b0, t); chk_cnt(t, a_of(v), a_of(v));
      wait_on(0, 1'b1, t); chk_cnt(t, n_of(v), n_of(v));
      chk_val(32'({data_oe, data_out}), 32'({1'b1, b + 8'h01}));
      wait_on(0, 1'b0, t);
      ahb(1, CTRL_ADDR, 32'h0, rd);
    end
    $display("test sync output done");
    ahb(1, PERIOD_ADDR, 32'(INHIBIT_CODE), rd);
    ahb(1, TXDATA_ADDR, 32'h3C, rd);
    ahb(1, CTRL_ADDR, 32'h7, rd);
    for (i = 0; i < 60; i++) begin @(posedge hclk); chk_val(32'(req_out), 0); end
    $display("test inhibit done");
    complete_run();
  end
endmodule : tb
